// file: common/ascs_pkg.sv
// ascs_pkg: register map, field layout, reset values and timing for the adc scan sequencer.
// assumes a 32-bit axi4-lite register bus and one 200 mhz system clock.
package ascs_pkg;
   localparam int AXI_AW = 8;
   localparam logic [7:0] OFS_RESULT = 8'h00;
   localparam logic [7:0] OFS_TRIGCH = 8'h04;
   localparam logic [7:0] OFS_CTLST = 8'h08;
   localparam logic [7:0] OFS_DIV = 8'h0c;
   // trigger/channel register fields
   localparam int TC_SMP_LSB = 0;
   localparam int TC_TSRC_LSB = 4;
   localparam int TC_RPT_BIT = 6;
   localparam int TC_JUST_BIT = 7;
   localparam int TC_FIRST_LSB = 8;
   localparam int TC_LAST_LSB = 11;
   // control/status register fields
   localparam int CS_EN_BIT = 0;
   localparam int CS_RUN_BIT = 1;
   localparam int CS_DIE_BIT = 4;
   localparam int CS_OIE_BIT = 5;
   localparam int CS_DONE_BIT = 8;
   localparam int CS_OVR_BIT = 9;
   localparam int CS_BUSY_BIT = 10;
   localparam int CS_ACH_LSB = 12;
   localparam logic [2:0] SMP_RESET = 3'h7;
   localparam logic [3:0] SMP_BASE = 4'h2;
   localparam logic [3:0] CONV_CYCLES = 4'hb;
   localparam logic [1:0] TSRC_SW = 2'h0;
   localparam logic [1:0] TSRC_TIMER = 2'h1;
   localparam logic [1:0] TSRC_EXT = 2'h3;
   localparam logic [2:0] CH_MAX = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [3:0] DIV_RESET = 4'h0;
   localparam logic [3:0] DIV_MAX = 4'he;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_CONVERT
   } ascs_phase_e;
endpackage : ascs_pkg

// file: rtl/ascs_top.sv
// ascs_top: scan sequencer for a 10-bit successive-approximation converter, axi4-lite slave.
// assumes the analog front end holds a valid result in the last cycle of o_afe_convert, and synchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module ascs_top #(
   parameter int DATA_W = 10
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [ascs_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ascs_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic i_timer_underflow,
   input wire logic i_ext_trigger_pin_n,
   input wire logic [DATA_W-1:0] i_afe_result,
   output logic o_afe_sample,
   output logic o_afe_convert,
   output logic [2:0] o_afe_channel,
   output logic o_irq
);
   import ascs_pkg::*;

   initial begin
      if (DATA_W != 10) begin
         $error("ascs_top supports only a 10-bit converter");
      end
   end

   typedef struct packed {
      logic awr;
      logic [AXI_AW-1:0] awaddr;
      logic wr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [2:0] smp_code;
      logic [1:0] tsrc;
      logic rpt;
      logic justify;
      logic [2:0] first_ch;
      logic [2:0] last_ch;
      logic [3:0] div_sel;
      logic enable;
      logic run;
      logic die;
      logic oie;
      logic done;
      logic ovr;
      logic [2:0] ach;
      logic [15:0] result;
      ascs_phase_e phase;
      logic [3:0] cyc;
      logic [15:0] div_cnt;
      logic ext_prev;
      logic irq;
   } ascs_state_s;

   ascs_state_s st_ff;
   ascs_state_s nxt_st;

   // divider ratio 2^(sel+1); code 0xf reserved, treated as the slowest
   function automatic logic [15:0] div_limit(input logic [3:0] sel);
      logic [3:0] s;
      s = (sel > DIV_MAX) ? DIV_MAX : sel;
      return 16'((32'h2 << s) - 32'h1);
   endfunction : div_limit

   function automatic logic [15:0] justify_word(input logic left, input logic [9:0] d);
      return left ? {d, 6'h00} : {6'h00, d};
   endfunction : justify_word

   logic clk_en;
   logic wr_go;
   logic rd_go;
   logic wr_ctl;
   logic trig_hit;
   logic ch_done;
   logic [31:0] rd_word;

   assign clk_en = (st_ff.div_cnt == div_limit(st_ff.div_sel));
   assign wr_go = st_ff.awr && st_ff.wr && !st_ff.bvalid;
   assign rd_go = s_axi_arvalid && st_ff.arready;
   assign wr_ctl = wr_go && (st_ff.awaddr == OFS_CTLST) && st_ff.wstrb[0];

   always_comb begin
      rd_word = 32'h0;
      case (s_axi_araddr)
         OFS_RESULT: rd_word = {16'h0, st_ff.result};
         OFS_TRIGCH: begin
            rd_word[TC_SMP_LSB +: 3] = st_ff.smp_code;
            rd_word[TC_TSRC_LSB +: 2] = st_ff.tsrc;
            rd_word[TC_RPT_BIT] = st_ff.rpt;
            rd_word[TC_JUST_BIT] = st_ff.justify;
            rd_word[TC_FIRST_LSB +: 3] = st_ff.first_ch;
            rd_word[TC_LAST_LSB +: 3] = st_ff.last_ch;
         end
         OFS_CTLST: begin
            rd_word[CS_EN_BIT] = st_ff.enable;
            rd_word[CS_RUN_BIT] = st_ff.run;
            rd_word[CS_DIE_BIT] = st_ff.die;
            rd_word[CS_OIE_BIT] = st_ff.oie;
            rd_word[CS_DONE_BIT] = st_ff.done;
            rd_word[CS_OVR_BIT] = st_ff.ovr;
            rd_word[CS_BUSY_BIT] = st_ff.run;
            rd_word[CS_ACH_LSB +: 3] = st_ff.ach;
         end
         OFS_DIV: rd_word[3:0] = st_ff.div_sel;
         default: rd_word = 32'h0;
      endcase
   end

   // trigger source decode; reserved code never fires
   always_comb begin
      trig_hit = 1'b0;
      case (st_ff.tsrc)
         TSRC_SW: trig_hit = wr_ctl && st_ff.wdata[CS_RUN_BIT];
         TSRC_TIMER: trig_hit = i_timer_underflow;
         TSRC_EXT: trig_hit = st_ff.ext_prev && !i_ext_trigger_pin_n;
         default: trig_hit = 1'b0;
      endcase
   end

   assign ch_done = clk_en && (st_ff.phase == ST_CONVERT) && (st_ff.cyc == 4'h1);

   always_comb begin
      nxt_st = st_ff;
      nxt_st.ext_prev = i_ext_trigger_pin_n;
      nxt_st.div_cnt = clk_en ? 16'h0 : 16'(st_ff.div_cnt + 16'h1);
      // write channels may arrive in either order
      if (!st_ff.awr && s_axi_awvalid) begin
         nxt_st.awr = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (!st_ff.wr && s_axi_wvalid) begin
         nxt_st.wr = 1'b1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
         nxt_st.awr = 1'b0;
         nxt_st.wr = 1'b0;
      end
      if (wr_go) begin
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = RESP_OKAY;
         case (st_ff.awaddr)
            OFS_RESULT: begin
            end
            OFS_TRIGCH: begin
               if (st_ff.wstrb[0]) begin
                  nxt_st.smp_code = st_ff.wdata[TC_SMP_LSB +: 3];
                  nxt_st.tsrc = st_ff.wdata[TC_TSRC_LSB +: 2];
                  nxt_st.rpt = st_ff.wdata[TC_RPT_BIT];
                  nxt_st.justify = st_ff.wdata[TC_JUST_BIT];
               end
               if (st_ff.wstrb[1]) begin
                  nxt_st.first_ch = st_ff.wdata[TC_FIRST_LSB +: 3];
                  nxt_st.last_ch = st_ff.wdata[TC_LAST_LSB +: 3];
               end
            end
            OFS_CTLST: begin
               if (st_ff.wstrb[0]) begin
                  nxt_st.enable = st_ff.wdata[CS_EN_BIT];
                  nxt_st.die = st_ff.wdata[CS_DIE_BIT];
                  nxt_st.oie = st_ff.wdata[CS_OIE_BIT];
               end
               if (st_ff.wstrb[1] && st_ff.wdata[CS_OVR_BIT]) begin
                  nxt_st.ovr = 1'b0;
               end
            end
            OFS_DIV: begin
               if (st_ff.wstrb[0]) begin
                  nxt_st.div_sel = st_ff.wdata[3:0];
               end
            end
            default: nxt_st.bresp = RESP_SLVERR;
         endcase
      end
      // read channel
      nxt_st.arready = !st_ff.rvalid && !rd_go;
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (rd_go) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = rd_word;
         nxt_st.rresp = (s_axi_araddr[7:4] == 4'h0 && s_axi_araddr[1:0] == 2'h0)
                        ? RESP_OKAY : RESP_SLVERR;
         if (s_axi_araddr == OFS_RESULT) begin
            nxt_st.done = 1'b0;
         end
      end
      // scan sequencer
      if (!st_ff.run) begin
         if (st_ff.enable && trig_hit) begin
            nxt_st.run = 1'b1;
            nxt_st.ach = st_ff.first_ch;
            nxt_st.phase = ST_SAMPLE;
            nxt_st.cyc = 4'(st_ff.smp_code) + SMP_BASE;
         end
      end else if (wr_ctl && !st_ff.wdata[CS_RUN_BIT]) begin
         nxt_st.run = 1'b0;
         nxt_st.phase = ST_IDLE;
         nxt_st.cyc = 4'h0;
      end else if (clk_en) begin
         if (st_ff.cyc != 4'h1) begin
            nxt_st.cyc = st_ff.cyc - 4'h1;
         end else if (st_ff.phase == ST_SAMPLE) begin
            nxt_st.phase = ST_CONVERT;
            nxt_st.cyc = CONV_CYCLES;
         end else begin
            nxt_st.result = justify_word(st_ff.justify, i_afe_result);
            nxt_st.done = 1'b1;
            if (st_ff.done) begin
               nxt_st.ovr = 1'b1;
            end
            if (st_ff.ach == st_ff.last_ch && !st_ff.rpt) begin
               nxt_st.run = 1'b0;
               nxt_st.phase = ST_IDLE;
               nxt_st.cyc = 4'h0;
            end else begin
               nxt_st.ach = (st_ff.ach == st_ff.last_ch) ? st_ff.first_ch
                          : ((st_ff.ach == CH_MAX) ? 3'h0 : st_ff.ach + 3'h1);
               nxt_st.phase = ST_SAMPLE;
               nxt_st.cyc = 4'(st_ff.smp_code) + SMP_BASE;
            end
         end
      end
      // read-clear and hardware set in one cycle: set wins
      if (ch_done && st_ff.run && !(wr_ctl && !st_ff.wdata[CS_RUN_BIT])) begin
         nxt_st.done = 1'b1;
      end
      nxt_st.irq = (nxt_st.done && nxt_st.die) || (nxt_st.ovr && nxt_st.oie);
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         st_ff <= '0;
         st_ff.smp_code <= SMP_RESET;
         st_ff.div_sel <= DIV_RESET;
         st_ff.ext_prev <= 1'b1;
         st_ff.phase <= ST_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign s_axi_awready = !st_ff.awr;
   assign s_axi_wready = !st_ff.wr;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_arready = st_ff.arready;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   assign o_afe_sample = (st_ff.phase == ST_SAMPLE);
   assign o_afe_convert = (st_ff.phase == ST_CONVERT);
   assign o_afe_channel = st_ff.ach;
   assign o_irq = st_ff.irq;
endmodule : ascs_top
`default_nettype wire

// file: sim/ascs_afe_model.sv
// ascs_afe_model: behavioural analog front end answering the sequencer.
// assumes the result is taken while o_afe_convert is high.
`timescale 1ns/1ps
`default_nettype none
module ascs_afe_model (
   input wire logic i_convert,
   input wire logic [2:0] i_channel,
   output logic [9:0] o_result
);
   // value tells the channel apart; outside a conversion it is inverted so stale reads show
   always_comb begin
      o_result = {i_channel, 7'h2b};
      if (!i_convert) begin
         o_result = ~o_result;
      end
   end
endmodule : ascs_afe_model
`default_nettype wire

// file: sim/ascs_properties.sv
// ascs_properties: port assertions for ascs_top.
// assumes the divider stays at reset, so one tick is two system clocks.
`timescale 1ns/1ps
`default_nettype none
module ascs_properties (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic o_afe_sample,
   input wire logic o_afe_convert,
   input wire logic [2:0] o_afe_channel
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   property p_wr_busy;
      s_wr_taken |=> !s_axi_awready && !s_axi_wready;
   endproperty
   a_wr_busy: assert property (p_wr_busy) else $error("write ready stayed high");
   property p_wr_resp;
      s_wr_taken |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_resp;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_r_resp: assert property (p_r_resp) else $error("read response late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_phase_excl;
      !(o_afe_sample && o_afe_convert);
   endproperty
   a_phase_excl: assert property (p_phase_excl) else $error("sample and convert overlap");
   property p_cnv_start;
      $rose(o_afe_convert) |-> $past(o_afe_sample);
   endproperty
   a_cnv_start: assert property (p_cnv_start) else $error("convert without sampling");
   property p_smp_min;
      $rose(o_afe_sample) |-> o_afe_sample [*3];
   endproperty
   a_smp_min: assert property (p_smp_min) else $error("sampling too short");
   property p_ch_hold;
      o_afe_convert && $past(o_afe_convert) |-> $stable(o_afe_channel);
   endproperty
   a_ch_hold: assert property (p_ch_hold) else $error("channel moved in conversion");
endmodule : ascs_properties
bind ascs_top ascs_properties i_ascs_properties (.i_clk_sys, .i_rst, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .o_afe_sample, .o_afe_convert, .o_afe_channel);
`default_nettype wire

// file: sim/test_adc_scan_sequencer.sv
// test_adc_scan_sequencer: register-level tests of the scan sequencer.
// assumes ascs_top with the afe model; divider left at reset value.
`timescale 1ns/1ps
`default_nettype none
module test_adc_scan_sequencer;
   import ascs_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, i_timer_underflow = 0, i_ext_trigger_pin_n = 1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic o_afe_sample, o_afe_convert, o_irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [2:0] o_afe_channel;
   logic [9:0] i_afe_result;
   int failures = 0;
   int n_tests = 0;
   int cyc = 0;
   always #2.5 i_clk_sys = ~i_clk_sys;
   ascs_top i_ascs_top (.i_clk_sys, .i_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .i_timer_underflow, .i_ext_trigger_pin_n,
      .i_afe_result, .o_afe_sample, .o_afe_convert, .o_afe_channel, .o_irq);
   ascs_afe_model i_ascs_afe_model (.i_convert(o_afe_convert), .i_channel(o_afe_channel),
      .o_result(i_afe_result));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      fork
         begin do @(posedge i_clk_sys); while (!s_axi_awready); s_axi_awvalid <= 0; end
         begin do @(posedge i_clk_sys); while (!s_axi_wready); s_axi_wvalid <= 0; end
      join
      while (!s_axi_bvalid) @(posedge i_clk_sys);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge i_clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge i_clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge i_clk_sys); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask : rd
   // polling the status keeps the wait tied to the design, not to a cycle guess
   task automatic wait_idle();
      do rd(OFS_CTLST); while (d[CS_RUN_BIT] !== 1'b0);
   endtask : wait_idle
   task automatic pulse(input int ext);
      @(posedge i_clk_sys);
      if (ext != 0) i_ext_trigger_pin_n <= 0;
      else i_timer_underflow <= 1;
      // timer underflow is a one-cycle pulse; the pin stays low for two clocks
      @(posedge i_clk_sys);
      i_timer_underflow <= 0;
      @(posedge i_clk_sys);
      i_ext_trigger_pin_n <= 1;
   endtask : pulse
   function automatic logic [31:0] res(input logic [2:0] c, input logic left);
      return left ? {16'h0, c, 7'h2b, 6'h0} : {22'h0, c, 7'h2b};
   endfunction : res
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         results();
      end
   end
   initial begin
      repeat (10) @(posedge i_clk_sys);
      i_rst <= 0;
      repeat (2) @(posedge i_clk_sys);
      rd(OFS_TRIGCH); chk("trigch reset", d, 32'h7);
      rd(8'h10); chk("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
      wr(8'h10, 32'h0); chk("unmapped wr resp", {30'h0, r}, {30'h0, RESP_SLVERR});
      wr(OFS_DIV, 32'h0); chk("div wr resp", {30'h0, r}, {30'h0, RESP_OKAY});
      $display("test 1 done");
      // channels 7 then 0, left justified, one shot, done irq on
      wr(OFS_TRIGCH, 32'h0780);
      wr(OFS_CTLST, 32'h11);
      wr(OFS_CTLST, 32'h13);
      wait_idle();
      chk("irq done", {31'h0, o_irq}, 32'h1);
      chk("ctl after scan", d & 32'h0fff, 32'h311);
      rd(OFS_RESULT); chk("result left", d, res(3'h0, 1'b1));
      rd(OFS_CTLST); chk("done cleared", d & 32'h0fff, 32'h211);
      chk("irq masked ovr", {31'h0, o_irq}, 32'h0);
      wr(OFS_CTLST, 32'h31);
      rd(OFS_CTLST); chk("ovr write 0", d & 32'h0fff, 32'h231);
      chk("irq ovr", {31'h0, o_irq}, 32'h1);
      wr(OFS_CTLST, 32'h231);
      rd(OFS_CTLST); chk("ovr w1c", d & 32'h0fff, 32'h031);
      chk("irq cleared", {31'h0, o_irq}, 32'h0);
      wr(OFS_CTLST, 32'h0);
      $display("test 2 done");
      // timer source, continuous on channel 3
      wr(OFS_TRIGCH, 32'h1b50);
      wr(OFS_CTLST, 32'h1);
      pulse(1);
      wr(OFS_CTLST, 32'h3);
      rd(OFS_CTLST); chk("other sources ignored", d & 32'h3, 32'h1);
      pulse(0);
      repeat (3) @(negedge o_afe_convert);
      rd(OFS_CTLST); chk("ctl running", d, 32'h3703);
      @(posedge o_afe_convert);
      rd(OFS_RESULT); chk("result right", d, res(3'h3, 1'b0));
      wr(OFS_CTLST, 32'h1);
      repeat (30) @(posedge i_clk_sys);
      rd(OFS_CTLST); chk("abort stores nothing", d & 32'h0fff, 32'h201);
      wr(OFS_CTLST, 32'h0);
      $display("test 3 done");
      wr(OFS_TRIGCH, 32'h1230);
      wr(OFS_CTLST, 32'h1);
      pulse(1);
      wait_idle();
      rd(OFS_RESULT); chk("ext result", d, res(3'h2, 1'b0));
      wr(OFS_CTLST, 32'h0);
      wr(OFS_TRIGCH, 32'h1220);
      wr(OFS_CTLST, 32'h3);
      rd(OFS_CTLST); chk("reserved source", d & 32'h3, 32'h1);
      $display("test 4 done");
      results();
   end
endmodule : test_adc_scan_sequencer
`default_nettype wire
